// ==== nvmac_pkg.sv ====
// Shared constants for the data EEPROM access control block.
package nvmac_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          DEPTH           = 256;
    // Register select codes on the special function register port.
    localparam logic [1:0]  SEL_CONTROL     = 2'h0;
    localparam logic [1:0]  SEL_UNLOCK      = 2'h1;
    localparam logic [1:0]  SEL_BUFFER      = 2'h2;
    localparam logic [1:0]  SEL_POINTER     = 2'h3;
    // Control register field positions.
    localparam int          BIT_PROG_SEL    = 7;
    localparam int          BIT_CFG_SEL     = 6;
    localparam int          BIT_ROW_ERASE   = 4;
    localparam int          BIT_ABORT       = 3;
    localparam int          BIT_PERMIT      = 2;
    localparam int          BIT_LAUNCH      = 1;
    localparam int          BIT_READ        = 0;
    // Unlock keys.
    localparam logic [7:0]  KEY_FIRST       = 8'h55;
    localparam logic [7:0]  KEY_SECOND      = 8'hAA;
    // Reset values.
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    // Self-timed write length, in time and in 8 ns core cycles.
    localparam int          WRITE_TIME_US   = 4;
    localparam int          CLK_MHZ         = 125;
    localparam int          WRITE_CYCLES    = WRITE_TIME_US * CLK_MHZ;
    localparam int          TIMER_W         = 16;
endpackage

// ==== nvmac_cell_array.sv ====
// Byte-wide nonvolatile cell array model with combinational read and erase-then-program write.
`timescale 1ns/100ps
module nvmac_cell_array #(
    parameter int DEPTH  = nvmac_pkg::DEPTH,
    parameter int ADDR_W = nvmac_pkg::ADDR_W,
    parameter int DATA_W = nvmac_pkg::DATA_W
) (
    input  wire logic              clock,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              eraseEn,
    input  wire logic              programEn,
    input  wire logic [DATA_W-1:0] wrData,
    output logic      [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] cells [DEPTH];

    // Erase drives a byte to all ones; programming then lands the new value.
    always_ff @(posedge clock) begin
        if (eraseEn) begin
            cells[addr] <= '1;
        end else if (programEn) begin
            cells[addr] <= wrData;
        end
    end

    assign rdData = cells[addr];
endmodule

// ==== nvmac_access_control.sv ====
// Data EEPROM access control: byte pointer, byte buffer, control register and unlock port.
`timescale 1ns/100ps
module nvmac_access_control #(
    parameter int WRITE_CYCLES = nvmac_pkg::WRITE_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       abortReset,
    input  wire logic [1:0] regSel,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    input  wire logic       storeDoneClear,
    output logic            storeDoneFlag,
    output logic            programMemorySelect,
    output logic            configSpaceSelect,
    output logic            rowEraseStart,
    output logic            busy
);
    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_GOT1  = 3'b010,
        KEY_ARMED = 3'b100
    } nvmac_key_t;

    typedef enum logic [2:0] {
        WR_IDLE    = 3'b001,
        WR_ERASE   = 3'b010,
        WR_PROGRAM = 3'b100
    } nvmac_wr_t;

    typedef struct packed {
        logic [7:0]                       pointer;
        logic [7:0]                       buffer;
        logic                             progSel;
        logic                             cfgSel;
        logic                             rowErase;
        logic                             abortFlag;
        logic                             permit;
        logic                             launch;
        logic                             readBit;
        logic                             doneFlag;
        logic                             rowPulse;
        nvmac_key_t                       keyState;
        nvmac_wr_t                        wrState;
        logic [nvmac_pkg::TIMER_W-1:0]    timer;
        logic [nvmac_pkg::TIMER_W-1:0]    busyCount;
        logic [7:0]                       rdData;
    } nvmac_state_t;

    localparam logic [nvmac_pkg::TIMER_W-1:0] HALF_CYCLES =
        nvmac_pkg::TIMER_W'((WRITE_CYCLES + 1) / 2);
    localparam logic [nvmac_pkg::TIMER_W-1:0] REST_CYCLES =
        nvmac_pkg::TIMER_W'(WRITE_CYCLES - (WRITE_CYCLES + 1) / 2);
    localparam logic [nvmac_pkg::TIMER_W-1:0] FULL_CYCLES =
        nvmac_pkg::TIMER_W'(WRITE_CYCLES);

    nvmac_state_t state_reg;
    nvmac_state_t state_next;
    logic [7:0]   arrayData;
    logic         ctlWrite;
    logic         keyWrite;
    logic         launchReq;
    logic         eraseEn;
    logic         programEn;

    nvmac_cell_array u_cells (
        .clock     (clock),
        .addr      (state_reg.pointer),
        .eraseEn   (eraseEn),
        .programEn (programEn),
        .wrData    (state_reg.buffer),
        .rdData    (arrayData)
    );

    assign ctlWrite  = regWrite && (regSel == nvmac_pkg::SEL_CONTROL);
    assign keyWrite  = regWrite && (regSel == nvmac_pkg::SEL_UNLOCK);
    // the permit must already be stored, so setting both at once fails.
    assign launchReq = ctlWrite && regWrData[nvmac_pkg::BIT_LAUNCH]
                       && (state_reg.keyState == KEY_ARMED) && state_reg.permit
                       && !state_reg.launch;
    assign eraseEn   = (state_reg.wrState == WR_ERASE) && (state_reg.timer == '0)
                       && !state_reg.progSel && !state_reg.cfgSel;
    assign programEn = (state_reg.wrState == WR_PROGRAM) && (state_reg.timer == '0)
                       && !state_reg.progSel && !state_reg.cfgSel;

    always_comb begin
        state_next = state_reg;
        state_next.rowPulse = 1'b0;

        // any register write that is not the expected step drops the sequence.
        if (regWrite) begin
            state_next.keyState = KEY_IDLE;
            if (keyWrite && regWrData == nvmac_pkg::KEY_FIRST
                && state_reg.keyState == KEY_IDLE) begin
                state_next.keyState = KEY_GOT1;
            end else if (keyWrite && regWrData == nvmac_pkg::KEY_SECOND
                && state_reg.keyState == KEY_GOT1) begin
                state_next.keyState = KEY_ARMED;
            end
        end

        if (regWrite && regSel == nvmac_pkg::SEL_POINTER) begin
            state_next.pointer = regWrData;
        end
        if (regWrite && regSel == nvmac_pkg::SEL_BUFFER) begin
            state_next.buffer = regWrData;
        end

        if (ctlWrite) begin
            state_next.progSel   = regWrData[nvmac_pkg::BIT_PROG_SEL];
            state_next.cfgSel    = regWrData[nvmac_pkg::BIT_CFG_SEL];
            state_next.abortFlag = regWrData[nvmac_pkg::BIT_ABORT];
            state_next.permit    = regWrData[nvmac_pkg::BIT_PERMIT];
            // Select bits are frozen while a cycle runs so the target cannot shift.
            if (state_reg.launch) begin
                state_next.progSel = state_reg.progSel;
                state_next.cfgSel  = state_reg.cfgSel;
            end else begin
                state_next.rowErase = regWrData[nvmac_pkg::BIT_ROW_ERASE];
            end
            // read set-only and refused with program select.
            if (regWrData[nvmac_pkg::BIT_READ] && !state_reg.progSel
                && !state_reg.launch) begin
                state_next.readBit = 1'b1;
            end
        end

        // one-cycle read into the byte buffer unless config select is set, then self-clear.
        if (state_reg.readBit) begin
            state_next.readBit = 1'b0;
            if (!state_reg.cfgSel) begin
                state_next.buffer = arrayData;
            end
        end

        // launch runs the timed cycle; software can never clear it.
        if (launchReq) begin
            state_next.launch   = 1'b1;
            state_next.keyState = KEY_IDLE;
            state_next.wrState  = WR_ERASE;
            state_next.timer    = HALF_CYCLES - 1'b1;
            state_next.rowPulse = state_reg.rowErase && state_reg.progSel;
        end

        // the clear goes first, so a completion in the same cycle wins.
        if (storeDoneClear) begin
            state_next.doneFlag = 1'b0;
        end

        case (state_reg.wrState)
            WR_IDLE: begin
            end
            WR_ERASE: begin
                if (state_reg.timer == '0) begin
                    // A row erase has no programming phase.
                    if (state_reg.rowErase) begin
                        state_next.wrState  = WR_IDLE;
                        state_next.launch   = 1'b0;
                        state_next.rowErase = 1'b0;
                        state_next.doneFlag = 1'b1;
                    end else begin
                        state_next.wrState = WR_PROGRAM;
                        state_next.timer   = (REST_CYCLES == '0) ? '0 : REST_CYCLES - 1'b1;
                    end
                end else begin
                    state_next.timer = state_reg.timer - 1'b1;
                end
            end
            WR_PROGRAM: begin
                if (state_reg.timer == '0) begin
                    state_next.wrState  = WR_IDLE;
                    state_next.launch   = 1'b0;
                    state_next.doneFlag = 1'b1;
                end else begin
                    state_next.timer = state_reg.timer - 1'b1;
                end
            end
            default: begin
                state_next.wrState = WR_IDLE;
                state_next.launch  = 1'b0;
            end
        endcase

        // interrupting reset, select bits kept for tracing.
        if (abortReset) begin
            if (state_reg.launch) begin
                state_next.abortFlag = 1'b1;
                state_next.pointer   = nvmac_pkg::RST_BYTE;
                state_next.buffer    = nvmac_pkg::RST_BYTE;
            end
            state_next.launch   = 1'b0;
            state_next.readBit  = 1'b0;
            state_next.permit   = 1'b0;
            state_next.keyState = KEY_IDLE;
            state_next.wrState  = WR_IDLE;
            state_next.timer    = '0;
        end

        // busy cycles are counted so the whole write length can be checked.
        state_next.busyCount = state_next.launch ? state_reg.busyCount + 1'b1 : '0;

        // the unlock port has no storage and reads zero.
        state_next.rdData = 8'h00;
        if (regRead) begin
            case (regSel)
                nvmac_pkg::SEL_CONTROL: begin
                    state_next.rdData = {state_next.progSel, state_next.cfgSel, 1'b0,
                                         state_next.rowErase, state_next.abortFlag,
                                         state_next.permit, state_next.launch,
                                         state_next.readBit};
                end
                nvmac_pkg::SEL_BUFFER:  state_next.rdData = state_next.buffer;
                nvmac_pkg::SEL_POINTER: state_next.rdData = state_next.pointer;
                default:                state_next.rdData = 8'h00;
            endcase
        end
    end

    // the permit resets to zero on power-up.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= '{pointer: 8'h00, buffer: 8'h00, progSel: 1'b0, cfgSel: 1'b0,
                           rowErase: 1'b0, abortFlag: 1'b0, permit: 1'b0,
                           launch: 1'b0, readBit: 1'b0, doneFlag: 1'b0,
                           rowPulse: 1'b0, keyState: KEY_IDLE, wrState: WR_IDLE,
                           timer: '0, busyCount: '0, rdData: 8'h00};
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdData           = state_reg.rdData;
    assign storeDoneFlag       = state_reg.doneFlag;
    assign programMemorySelect = state_reg.progSel;
    assign configSpaceSelect   = state_reg.cfgSel;
    assign rowEraseStart       = state_reg.rowPulse;
    assign busy                = state_reg.launch;

    property p_launch_needs_keys;
        @(posedge clock) disable iff (reset)
        $rose(state_reg.launch) |-> $past(state_reg.keyState) == KEY_ARMED
                                    && $past(state_reg.permit);
    endproperty
    a_launch_needs_keys: assert property (p_launch_needs_keys) else $error("launch without unlock");

    property p_busy_length;
        @(posedge clock) disable iff (reset || abortReset)
        $rose(state_reg.launch) && !state_reg.rowErase |-> state_reg.launch [*2];
    endproperty
    a_busy_length: assert property (p_busy_length) else $error("write cycle ended early");

    // A row erase has no programming phase, so only full writes are timed here.
    property p_busy_full_length;
        @(posedge clock) disable iff (reset)
        $fell(state_reg.launch) && !$past(abortReset) && !$past(state_reg.rowErase)
            |-> $past(state_reg.busyCount) == FULL_CYCLES;
    endproperty
    a_busy_full_length: assert property (p_busy_full_length) else $error("write length wrong");

    property p_row_pulse;
        @(posedge clock) disable iff (reset)
        state_reg.rowPulse |-> $rose(state_reg.launch) && state_reg.progSel;
    endproperty
    a_row_pulse: assert property (p_row_pulse) else $error("row erase pulse without launch");

    property p_read_one_cycle;
        @(posedge clock) disable iff (reset)
        state_reg.readBit |=> !state_reg.readBit;
    endproperty
    a_read_one_cycle: assert property (p_read_one_cycle) else $error("read bit stuck");

    property p_read_refused;
        @(posedge clock) disable iff (reset)
        state_reg.progSel && !abortReset |=> !$rose(state_reg.readBit);
    endproperty
    a_read_refused: assert property (p_read_refused) else $error("read with program select");

    property p_done_sticky;
        @(posedge clock) disable iff (reset)
        state_reg.doneFlag && !storeDoneClear |=> state_reg.doneFlag;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

    property p_done_on_finish;
        @(posedge clock) disable iff (reset)
        $fell(state_reg.launch) && !$past(abortReset) |-> state_reg.doneFlag;
    endproperty
    a_done_on_finish: assert property (p_done_on_finish) else $error("no done flag");

    property p_abort_sets;
        @(posedge clock) disable iff (reset)
        abortReset && state_reg.launch |=> state_reg.abortFlag && state_reg.pointer == 8'h00
                                           && state_reg.buffer == 8'h00;
    endproperty
    a_abort_sets: assert property (p_abort_sets) else $error("abort not flagged");

    property p_abort_keeps_select;
        @(posedge clock) disable iff (reset)
        abortReset && state_reg.launch |=> $stable(state_reg.progSel);
    endproperty
    a_abort_keeps_select: assert property (p_abort_keeps_select) else $error("select lost");

    property p_unlock_reads_zero;
        @(posedge clock) disable iff (reset)
        regRead && regSel == nvmac_pkg::SEL_UNLOCK |=> regRdData == 8'h00;
    endproperty
    a_unlock_reads_zero: assert property (p_unlock_reads_zero) else $error("unlock read nonzero");
endmodule

// ==== nvmac_host_model.sv ====
// Processor-side model that issues register accesses to the access control block.
`timescale 1ns/100ps
module nvmac_host_model (
    input  wire logic       clock,
    output logic      [1:0] regSel,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWrData,
    input  wire logic [7:0] regRdData
);
    initial begin
        regSel    = 2'h0;
        regWrite  = 1'b0;
        regRead   = 1'b0;
        regWrData = 8'h00;
    end
    // Each access first waits a falling edge, so two calls never move a strobe in one step.
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(negedge clock);
        regSel    = sel;
        regWrData = d;
        regWrite  = 1'b1;
        @(negedge clock);
        regWrite  = 1'b0;
    endtask
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        @(negedge clock);
        regSel  = sel;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        d       = regRdData;
    endtask
    // The two keys go out with no other register write between them.
    task automatic unlock();
        wr(nvmac_pkg::SEL_UNLOCK, nvmac_pkg::KEY_FIRST);
        wr(nvmac_pkg::SEL_UNLOCK, nvmac_pkg::KEY_SECOND);
    endtask
endmodule

// ==== nvmac_access_control_tb.sv ====
// Self-checking testbench for the data EEPROM access control block.
`timescale 1ns/100ps
module nvmac_access_control_tb;
    // A short write keeps the run brief; the busy-cycle check and the wait bound derive from it, the fixed watchdog does not.
    localparam int WCYC = 8;
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] wd;
        logic [7:0] exp;
    } nvmac_row_t;
    logic       clock          = 1'b0;
    logic       reset          = 1'b1;
    logic       abortReset     = 1'b0;
    logic       storeDoneClear = 1'b0;
    logic [1:0] regSel;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic       storeDoneFlag;
    logic       programMemorySelect;
    logic       configSpaceSelect;
    logic       rowEraseStart;
    logic       busy;
    logic [7:0] v;
    int         failures = 0;
    int         n_checks = 0;
    int         rowSeen  = 0;
    int         n;
    nvmac_row_t rows [7];

    always #4 clock = ~clock;

    nvmac_access_control #(.WRITE_CYCLES(WCYC)) uut (
        .clock(clock), .reset(reset), .abortReset(abortReset), .regSel(regSel),
        .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
        .regRdData(regRdData), .storeDoneClear(storeDoneClear),
        .storeDoneFlag(storeDoneFlag), .programMemorySelect(programMemorySelect),
        .configSpaceSelect(configSpaceSelect), .rowEraseStart(rowEraseStart), .busy(busy)
    );
    nvmac_host_model host (
        .clock(clock), .regSel(regSel), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData)
    );

    always @(posedge clock) begin
        if (rowEraseStart === 1'b1) begin
            rowSeen <= rowSeen + 1;
        end
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk1(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic launch(input logic [7:0] ptr, input logic [7:0] d, input logic [7:0] base);
        host.wr(nvmac_pkg::SEL_POINTER, ptr);
        host.wr(nvmac_pkg::SEL_BUFFER, d);
        host.wr(nvmac_pkg::SEL_CONTROL, base | 8'h04);
        host.unlock();
        host.wr(nvmac_pkg::SEL_CONTROL, base | 8'h06);
    endtask
    // Counts busy cycles up to a bound, so a stuck cycle cannot hang the run.
    task automatic wait_idle();
        n = 0;
        while (busy === 1'b1 && n < 4 * WCYC) begin
            n++;
            @(negedge clock);
        end
    endtask
    task automatic ee_read(input logic [7:0] a, output logic [7:0] d);
        host.wr(nvmac_pkg::SEL_POINTER, a);
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h01);
        host.rd(nvmac_pkg::SEL_BUFFER, d);
    endtask

    initial begin
        #(8 * 20000);
        failures++;
        $display("Error watchdog expected finish seen timeout");
        final_report();
    end

    initial begin
        rows = '{'{nvmac_pkg::SEL_POINTER, 8'hFF, 8'hFF}, '{nvmac_pkg::SEL_BUFFER, 8'h5A, 8'h5A},
                 '{nvmac_pkg::SEL_UNLOCK, 8'h55, 8'h00}, '{nvmac_pkg::SEL_CONTROL, 8'hE0, 8'hC0},
                 '{nvmac_pkg::SEL_CONTROL, 8'h00, 8'h00}, '{nvmac_pkg::SEL_CONTROL, 8'h06, 8'h04},
                 '{nvmac_pkg::SEL_CONTROL, 8'h00, 8'h00}};
        repeat (16) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) begin
            host.rd(2'(i), v);
            chk8("reset value", nvmac_pkg::RST_BYTE, v);
        end
        chk1("busy after reset", 1'b0, busy);
        foreach (rows[i]) begin
            host.wr(rows[i].sel, rows[i].wd);
            host.rd(rows[i].sel, v);
            chk8("register read", rows[i].exp, v);
            chk1("busy after single write", 1'b0, busy);
            if (rows[i].sel === nvmac_pkg::SEL_CONTROL) begin
                chk1("program select", rows[i].exp[7], programMemorySelect);
                chk1("config select", rows[i].exp[6], configSpaceSelect);
            end
        end
        launch(8'hFF, 8'hA5, 8'h00);
        wait_idle();
        chk8("busy cycles", 8'(WCYC), 8'(n));
        chk1("done flag", 1'b1, storeDoneFlag);
        host.rd(nvmac_pkg::SEL_CONTROL, v);
        chk8("control after write", 8'h04, v);
        chk1("done flag held", 1'b1, storeDoneFlag);
        storeDoneClear = 1'b1;
        @(negedge clock);
        storeDoneClear = 1'b0;
        @(negedge clock);
        chk1("done flag cleared", 1'b0, storeDoneFlag);
        host.wr(nvmac_pkg::SEL_BUFFER, 8'h00);
        ee_read(8'hFF, v);
        chk8("read back top byte", 8'hA5, v);
        host.rd(nvmac_pkg::SEL_CONTROL, v);
        chk8("read bit cleared", 8'h00, v);
        host.rd(nvmac_pkg::SEL_BUFFER, v);
        chk8("buffer held", 8'hA5, v);
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h04);
        host.wr(nvmac_pkg::SEL_UNLOCK, nvmac_pkg::KEY_FIRST);
        host.wr(nvmac_pkg::SEL_BUFFER, 8'h3C);
        host.wr(nvmac_pkg::SEL_UNLOCK, nvmac_pkg::KEY_SECOND);
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h06);
        chk1("busy after stray write", 1'b0, busy);
        host.wr(nvmac_pkg::SEL_UNLOCK, nvmac_pkg::KEY_SECOND);
        host.wr(nvmac_pkg::SEL_UNLOCK, nvmac_pkg::KEY_FIRST);
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h06);
        chk1("busy after swapped keys", 1'b0, busy);
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h00);
        host.unlock();
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h06);
        chk1("busy without earlier permit", 1'b0, busy);
        chk1("no done flag", 1'b0, storeDoneFlag);
        host.wr(nvmac_pkg::SEL_BUFFER, 8'h77);
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h80);
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h81);
        host.rd(nvmac_pkg::SEL_CONTROL, v);
        chk8("read refused", 8'h80, v);
        host.rd(nvmac_pkg::SEL_BUFFER, v);
        chk8("buffer untouched", 8'h77, v);
        launch(8'h00, 8'h5A, 8'h00);
        host.wr(nvmac_pkg::SEL_CONTROL, 8'h00);
        chk1("busy after zero write", 1'b1, busy);
        wait_idle();
        ee_read(8'h00, v);
        chk8("bottom byte written", 8'h5A, v);
        n = rowSeen;
        launch(8'h20, 8'hC3, 8'h90);
        repeat (2) @(negedge clock);
        chk1("busy on program launch", 1'b1, busy);
        chk8("row erase pulses", 8'h01, 8'(rowSeen - n));
        abortReset = 1'b1;
        @(negedge clock);
        abortReset = 1'b0;
        @(negedge clock);
        chk1("busy after abort", 1'b0, busy);
        host.rd(nvmac_pkg::SEL_CONTROL, v);
        chk8("control after abort", 8'h98, v);
        host.rd(nvmac_pkg::SEL_POINTER, v);
        chk8("pointer after abort", 8'h00, v);
        host.rd(nvmac_pkg::SEL_BUFFER, v);
        chk8("buffer after abort", 8'h00, v);
        launch(8'h00, 8'h11, 8'h40);
        chk1("config select", 1'b1, configSpaceSelect);
        wait_idle();
        ee_read(8'h00, v);
        chk8("config launch leaves array", 8'h5A, v);
        final_report();
    end
endmodule
